// File: core/ucaf_consts.svh
// constants for the usb control, address and frame-number block
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef UCAF_CONSTS_SVH
`define UCAF_CONSTS_SVH
// register byte offsets
`define UCAF_OFF_CON     8'h00
`define UCAF_OFF_ADDR    8'h04
`define UCAF_OFF_FRAME_NUMBER_LOW_FIELD    8'h08
`define UCAF_OFF_FRAME_NUMBER_HIGH_FIELD    8'h0c
`define UCAF_OFF_TOK     8'h10
`define UCAF_OFF_STAT    8'h14
// control register field positions
`define UCAF_CON_EN      0
`define UCAF_CON_PINGPONG_POINTER_RESET  1
`define UCAF_CON_RESUME  2
`define UCAF_CON_HOST_MODE_ENABLE  3
`define UCAF_CON_BUSY    5
// address register fields
`define UCAF_ADDR_LS     7
// reset values
`define UCAF_RST_BYTE    8'h00
`define UCAF_RST_FRAME   11'h000
// timing: one frame is 1 ms at 100 MHz
`define UCAF_FRAME_NS    1000000
`define UCAF_CLK_NS      10
`define UCAF_FRAME_CYC   (`UCAF_FRAME_NS / `UCAF_CLK_NS)
// low-speed eop length after resume, in clock cycles (about 1.3 us)
`define UCAF_LSEOP_NS    1330
`define UCAF_LSEOP_CYC   (`UCAF_LSEOP_NS / `UCAF_CLK_NS)
`endif

// File: core/ucaf_frame_timer.sv
// frame-start timer: one-cycle pulse every frame period while enabled
// assumes a single clock; clear restarts the count
`timescale 1ns/1ps
`default_nettype none
module ucaf_frame_timer #(
  parameter int FRAME_CYC = 100000
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic enable_i,
  input  wire logic clear_i,
  // event
  output logic      tick_o
);
  initial begin
    if (FRAME_CYC < 2) $error("frame period too short");
  end

  logic [31:0] cnt_q;

  // count while enabled; stopping the enable also parks the counter
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !enable_i) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == 32'(FRAME_CYC - 1)) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // ucaf_frame_timer
`default_nettype wire

// File: core/ucaf_pkg.sv
// types for the usb control, address and frame-number block
// assumes nothing beyond the constants header
package ucaf_pkg;
  // resume signalling phases
  typedef enum logic [1:0] {
    UCAF_RS_IDLE  = 2'b00,
    UCAF_RS_DRIVE = 2'b01,
    UCAF_RS_EOP   = 2'b10
  } ucaf_rs_state_t;
endpackage

// File: core/ucaf_sync.sv
// three-stage synchroniser with an agreement filter on the last two stages
// assumes an asynchronous single-bit input
`timescale 1ns/1ps
`default_nettype none
module ucaf_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // data
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule // ucaf_sync
`default_nettype wire

// File: core/ucaf_top.sv
// usb control, address and frame-number registers behind a wishbone slave
// assumes the packet engine supplies sof capture, token done and pointer toggles
//
// Behaviour
// - ping-pong reset set to one returns every buffer pointer to even.
// - device mode: control bit 0 enables the module and its circuitry.
// - host mode: control bit 0 emits a frame-start token every millisecond.
// - any change of host-mode enable resets all host control logic; here it clears only the token register, busy flag and frame timer.
// - host mode: clearing resume appends a low-speed end-of-packet.
// - low-speed select one runs next token at low speed, else full.
// - address register holds a 7-bit device address, resets to zero.
// - frame number low eight bits read at bits 7 to 0.
// - frame number upper three bits read at bits 2 to 0.
// - every received frame-start token loads both frame registers.
// - bits above 7 (above 2 for high frame) ignore writes, read zero.
//
// Design decisions made here: the address map and the Wishbone slave port.
`include "ucaf_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ucaf_top
  import ucaf_pkg::*;
#(
  parameter int FRAME_CYC = `UCAF_FRAME_CYC,
  parameter int LSEOP_CYC = `UCAF_LSEOP_CYC,
  parameter int PP_EPS    = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // packet engine side
  input  wire logic        sof_rx_i,
  input  wire logic [10:0] sof_frame_i,
  input  wire logic        tok_done_i,
  input  wire logic        pp_toggle_i,
  input  wire logic [3:0]  pp_ep_i,
  input  wire logic        se0_pin_i,
  // control outputs
  output logic             module_enable_o,
  output logic             host_reset_o,
  output logic             sof_emit_o,
  output logic             resume_drive_o,
  output logic             ls_eop_o,
  output logic             low_speed_o,
  output logic [6:0]       dev_addr_o,
  output logic             tok_start_o,
  output logic [7:0]       tok_cmd_o,
  output logic [PP_EPS-1:0] pp_odd_o
);
  initial begin
    if (PP_EPS < 1 || PP_EPS > 16) $error("pp endpoint count out of range");
    if (LSEOP_CYC < 1 || LSEOP_CYC > 65535) $error("eop length out of range");
    if (FRAME_CYC < 2) $error("frame period too short");
  end

  // registers
  logic        en_q;
  logic        pingpong_pointer_reset_q;
  logic        resume_q;
  logic        host_mode_enable_q;
  logic        busy_q;
  logic [7:0]  addr_q;
  logic [10:0] frame_q;
  logic [7:0]  tok_q;
  logic        ack_q;
  logic        se0_sync;
  logic        sof_tick;
  logic        host_rst_q;
  logic        wr_stb;
  logic        byte0_wr;
  logic        tok_wr;
  ucaf_rs_state_t rs_q;
  logic [15:0] eop_cnt_q;
  logic [31:0] rd_d;

  // bus decode: a new access is taken only while ack is low
  assign wr_stb   = cyc_i && stb_i && we_i && !ack_q;
  assign byte0_wr = wr_stb && sel_i[0];
  assign tok_wr   = byte0_wr && (adr_i == `UCAF_OFF_TOK);

  // one wait-free answer, dropped in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end
  assign ack_o = ack_q;

  // live single-ended-zero level from the pin
  ucaf_sync u_se0 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (se0_pin_i),
    .level_o (se0_sync)
  );

  // control register writable bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q     <= 1'b0;
      pingpong_pointer_reset_q <= 1'b0;
      resume_q <= 1'b0;
      host_mode_enable_q <= 1'b0;
    end else if (byte0_wr && adr_i == `UCAF_OFF_CON) begin
      en_q     <= dat_i[`UCAF_CON_EN];
      pingpong_pointer_reset_q <= dat_i[`UCAF_CON_PINGPONG_POINTER_RESET];
      resume_q <= dat_i[`UCAF_CON_RESUME];
      host_mode_enable_q <= dat_i[`UCAF_CON_HOST_MODE_ENABLE];
    end
  end

  // any toggle of host enable pulses the host logic reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_rst_q <= 1'b0;
    end else begin
      host_rst_q <= byte0_wr && adr_i == `UCAF_OFF_CON
                    && dat_i[`UCAF_CON_HOST_MODE_ENABLE] != host_mode_enable_q;
    end
  end
  assign host_reset_o = host_rst_q;

  // ping-pong pointers per endpoint; reset wins while the control is held
  genvar g;
  generate
    for (g = 0; g < PP_EPS; g++) begin : g_pp
      always_ff @(posedge clk_i) begin
        if (rst_i || pingpong_pointer_reset_q) begin
          pp_odd_o[g] <= 1'b0;
        end else if (pp_toggle_i && pp_ep_i == 4'(g)) begin
          pp_odd_o[g] <= ~pp_odd_o[g];
        end
      end
    end
  endgenerate

  // host frame-start timer, restarted by the host reset
  ucaf_frame_timer #(
    .FRAME_CYC (FRAME_CYC)
  ) u_frame (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (en_q && host_mode_enable_q),
    .clear_i  (host_rst_q),
    .tick_o   (sof_tick)
  );
  assign sof_emit_o      = sof_tick;
  assign module_enable_o = en_q && !host_mode_enable_q;

  // token command register and busy flag; completion set by write wins
  always_ff @(posedge clk_i) begin
    if (rst_i || host_rst_q) begin
      tok_q  <= `UCAF_RST_BYTE;
      busy_q <= 1'b0;
    end else if (tok_wr && host_mode_enable_q) begin
      tok_q  <= dat_i[7:0];
      busy_q <= 1'b1;
    end else if (tok_done_i) begin
      busy_q <= 1'b0;
    end
  end

  // start pulse for the packet engine; the command is latched only when a
  // token is really started, so a refused write cannot disturb a running one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tok_start_o <= 1'b0;
      tok_cmd_o   <= `UCAF_RST_BYTE;
    end else begin
      tok_start_o <= tok_wr && host_mode_enable_q && !busy_q;
      if (tok_wr && host_mode_enable_q && !busy_q) begin
        tok_cmd_o <= dat_i[7:0];
      end
    end
  end

  // resume signalling; in host mode a low-speed eop follows the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_q      <= UCAF_RS_IDLE;
      eop_cnt_q <= 16'h0;
    end else begin
      unique case (rs_q)
        UCAF_RS_IDLE: begin
          if (resume_q) begin
            rs_q <= UCAF_RS_DRIVE;
          end
        end
        UCAF_RS_DRIVE: begin
          if (!resume_q) begin
            if (host_mode_enable_q) begin
              rs_q      <= UCAF_RS_EOP;
              eop_cnt_q <= 16'h0;
            end else begin
              rs_q <= UCAF_RS_IDLE;
            end
          end
        end
        UCAF_RS_EOP: begin
          if (eop_cnt_q == 16'(LSEOP_CYC - 1)) begin
            rs_q <= UCAF_RS_IDLE;
          end else begin
            eop_cnt_q <= eop_cnt_q + 16'h1;
          end
        end
        default: begin
          rs_q <= UCAF_RS_IDLE;
        end
      endcase
    end
  end
  assign resume_drive_o = (rs_q == UCAF_RS_DRIVE);
  assign ls_eop_o       = (rs_q == UCAF_RS_EOP);

  // address register: 7-bit address plus low-speed select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= `UCAF_RST_BYTE;
    end else if (byte0_wr && adr_i == `UCAF_OFF_ADDR) begin
      addr_q <= dat_i[7:0];
    end
  end
  assign low_speed_o = addr_q[`UCAF_ADDR_LS];
  assign dev_addr_o  = addr_q[6:0];

  // frame number: loaded only by a received frame-start token
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_q <= `UCAF_RST_FRAME;
    end else if (sof_rx_i) begin
      frame_q <= sof_frame_i;
    end
  end

  // read mux; unmapped offsets read zero and still acknowledge
  always_comb begin
    rd_d = 32'h0;
    unique case (adr_i)
      `UCAF_OFF_CON: begin
        rd_d[7] = !se0_sync;
        rd_d[6] = se0_sync;
        rd_d[`UCAF_CON_BUSY]   = busy_q;
        rd_d[`UCAF_CON_HOST_MODE_ENABLE] = host_mode_enable_q;
        rd_d[`UCAF_CON_RESUME] = resume_q;
        rd_d[`UCAF_CON_PINGPONG_POINTER_RESET] = pingpong_pointer_reset_q;
        rd_d[`UCAF_CON_EN]     = en_q;
      end
      `UCAF_OFF_ADDR: rd_d[7:0] = addr_q;
      `UCAF_OFF_FRAME_NUMBER_LOW_FIELD: rd_d[7:0] = frame_q[7:0];
      `UCAF_OFF_FRAME_NUMBER_HIGH_FIELD: rd_d[2:0] = frame_q[10:8];
      `UCAF_OFF_TOK:  rd_d[7:0] = tok_q;
      default:        rd_d = 32'h0;
    endcase
  end

  // read data held in a flop alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (cyc_i && stb_i && !ack_q) begin
      dat_o <= rd_d;
    end
  end
endmodule // ucaf_top
`default_nettype wire

// File: verification/ucaf_assertions.sv
// port checker for ucaf_top: bus timing, register writes, control pulses
// assumes a classic single-cycle wishbone master on the bus
`timescale 1ns/1ps
`default_nettype none
module ucaf_checker #(
  parameter int LSEOP_CYC = 4,
  parameter int PP_EPS    = 16
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // wishbone
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [7:0]        adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  // control outputs
  input wire logic              module_enable_o,
  input wire logic              host_reset_o,
  input wire logic              sof_emit_o,
  input wire logic              resume_drive_o,
  input wire logic              ls_eop_o,
  input wire logic              tok_start_o,
  input wire logic [PP_EPS-1:0] pp_odd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a control write as the block takes it
  wire        wcon = cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == 8'h00;
  logic       host_q;
  logic [7:0] eop_n_q;
  // host enable mirror, so a toggle is known without reading back
  always_ff @(posedge clk_i) begin
    if (rst_i) host_q <= 1'h0;
    else if (wcon) host_q <= dat_i[3];
  end
  // length of the current end-of-packet
  always_ff @(posedge clk_i) begin
    if (rst_i || !ls_eop_o) eop_n_q <= 8'h00;
    else eop_n_q <= eop_n_q + 8'h01;
  end
  AST_ACK_ONCE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a one-cycle pulse after the request");
  AST_LOW_RD: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h08 |-> dat_o[31:8] == 24'h0)
    else $error("frame low upper bits not zero");
  AST_FRAME_NUMBER_HIGH_FIELD_RD: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h0c |-> dat_o[31:3] == 29'h0)
    else $error("frame high upper bits not zero");
  AST_EN_WR: assert property (wcon && !dat_i[3] |-> ##2 module_enable_o == $past(dat_i[0], 2))
    else $error("module enable does not follow bit 0");
  AST_SOF_HOST: assert property (sof_emit_o |-> !module_enable_o ##1 !sof_emit_o [*8])
    else $error("frame start outside host mode or too close");
  AST_PP_CLR: assert property (wcon && dat_i[1] |-> ##2 pp_odd_o == '0)
    else $error("buffer pointers not back to even");
  AST_HOST_RST: assert property (wcon && dat_i[3] != host_q |-> ##[1:2] host_reset_o ##1 !host_reset_o)
    else $error("no host reset pulse on host enable toggle");
  AST_EOP_LEN: assert property ($fell(ls_eop_o) |-> eop_n_q == LSEOP_CYC && !resume_drive_o)
    else $error("low-speed end-of-packet length wrong");
  cover property (sof_emit_o);
  cover property ($fell(ls_eop_o));
  cover property (host_reset_o);
  cover property (tok_start_o);
endmodule // ucaf_checker
bind ucaf_top ucaf_checker #(.LSEOP_CYC(LSEOP_CYC), .PP_EPS(PP_EPS)) u_chk (.*);
`default_nettype wire

// File: verification/ucaf_partner.sv
// far-side packet engine stand-in: frame tokens, token completion, pointer flips
// assumes its tasks are called from one process at a time
`timescale 1ns/1ps
`default_nettype none
module ucaf_partner (
  // clock
  input  wire logic   clk_i,
  // towards the block
  output logic        sof_rx_i,
  output logic [10:0] sof_frame_i,
  output logic        tok_done_i,
  output logic        pp_toggle_i,
  output logic [3:0]  pp_ep_i,
  output logic        se0_pin_i
);
  // idle levels at time zero
  initial begin
    sof_rx_i = 1'h0;
    sof_frame_i = 11'h0;
    tok_done_i = 1'h0;
    pp_toggle_i = 1'h0;
    pp_ep_i = 4'h0;
    se0_pin_i = 1'h0;
  end
  // line state wanders unrelated to the clock, as a real bus would
  always #37 se0_pin_i = ~se0_pin_i;
  // frame token received; stale number inverted so it never looks valid
  task automatic send_sof(input logic [10:0] f);
    @(posedge clk_i);
    sof_rx_i <= 1'h1;
    sof_frame_i <= f;
    @(posedge clk_i);
    sof_rx_i <= 1'h0;
    sof_frame_i <= ~f;
    @(posedge clk_i);
  endtask
  // one pulse on a single-cycle strobe, with endpoint
  task automatic pulse(input logic done, input logic [3:0] ep);
    @(posedge clk_i);
    tok_done_i <= done;
    pp_toggle_i <= !done;
    pp_ep_i <= ep;
    @(posedge clk_i);
    tok_done_i <= 1'h0;
    pp_toggle_i <= 1'h0;
    pp_ep_i <= ~ep;
    @(posedge clk_i);
  endtask
endmodule // ucaf_partner
`default_nettype wire

// File: verification/ucaf_tb_top.sv
// self-checking bench for ucaf_top: wishbone master, reference values
// assumes ucaf_partner on the packet side and the checker bound to dut
`timescale 1ns/1ps
`default_nettype none
module ucaf_tb_top;
  // signals named as the ports, so instances connect by name
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0]  adr_i = 8'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, sof_rx_i, tok_done_i, pp_toggle_i, se0_pin_i, module_enable_o;
  logic        host_reset_o, sof_emit_o, resume_drive_o, ls_eop_o, low_speed_o, tok_start_o;
  logic [10:0] sof_frame_i;
  logic [3:0]  pp_ep_i;
  logic [6:0]  dev_addr_o;
  logic [7:0]  tok_cmd_o;
  logic [15:0] pp_odd_o;
  int          num_errors = 0, check_count = 0, n, m, hrc = 0, sfc = 0, tsc = 0, lec = 0;
  int          pid[$] = '{13, 9, 1};
  always #5 clk_i = ~clk_i;
  ucaf_top #(.FRAME_CYC(50), .LSEOP_CYC(4)) dut (.*);
  ucaf_partner u_far (.*);
  // pulse tallies on the falling edge, clear of the bench's own updates
  always @(negedge clk_i) begin
    hrc += host_reset_o;
    sfc += sof_emit_o;
    tsc += tok_start_o;
    lec += ls_eop_o;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'h1 && ++t < 20);
    if (ack_o !== 1'h1) begin
      num_errors++;
      $display("wrong value at %0t: no bus acknowledge", $time);
    end
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  // read and compare under a mask; line-state bits 7:6 are masked off
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(rd & 32'hffffff3f, e);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(58132));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int a = 4; a <= 20; a += 4) rdc(a[7:0], 0);
    wb(1'h1, 8'h18, $urandom);
    rdc(8'h18, 0);
    repeat (4) begin
      n = $urandom;
      wb(1'h1, 8'h04, n);
      wb(1'h0, 8'h04, 32'h0);
      chk(rd, n & 8'hff);
      chk({low_speed_o, dev_addr_o}, n & 8'hff);
    end
    $display("address and reset test done");
    for (int i = 0; i < 3; i++) begin
      n = i ? $urandom % 2048 : 2047;
      u_far.send_sof(n[10:0]);
      wb(1'h1, 8'h08, $urandom);
      wb(1'h1, 8'h0c, $urandom);
      wb(1'h0, 8'h08, 32'h0);
      chk(rd, n & 8'hff);
      rdc(8'h0c, n >> 8);
    end
    $display("frame number test done");
    wb(1'h1, 8'h00, 32'h1);
    @(posedge clk_i);
    chk(module_enable_o, 1);
    u_far.pulse(1'h0, 4'h3);
    chk(pp_odd_o, 16'h8);
    wb(1'h1, 8'h00, 32'h2);
    @(posedge clk_i);
    chk({module_enable_o, pp_odd_o}, 0);
    u_far.pulse(1'h0, 4'h5);
    chk(pp_odd_o, 0);
    $display("enable and pointer test done");
    m = hrc;
    wb(1'h1, 8'h00, 32'h9);
    repeat (20) @(posedge clk_i);
    chk(hrc - m, 1);
    n = sfc;
    repeat (200) @(posedge clk_i);
    chk(sfc - n, 4);
    m = tsc;
    foreach (pid[i]) begin
      n = pid[i] * 16 + $urandom % 16;
      wb(1'h1, 8'h10, n);
      rdc(8'h00, 32'h29);
      chk(tok_cmd_o, n);
      wb(1'h1, 8'h10, n ^ 1);
      u_far.pulse(1'h1, 4'h0);
      rdc(8'h00, 32'h09);
    end
    chk(tsc - m, 3);
    wb(1'h1, 8'h00, 32'hc);
    n = sfc;
    repeat (120) @(posedge clk_i);
    chk(sfc - n, 0);
    chk(resume_drive_o, 1);
    n = lec;
    wb(1'h1, 8'h00, 32'h8);
    repeat (20) @(posedge clk_i);
    chk(lec - n, 4);
    m = hrc;
    wb(1'h1, 8'h00, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(hrc - m, 1);
    $display("host test done");
    close_out();
  end
  // hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule // ucaf_tb_top
`default_nettype wire
